// ---- hdl/bwlo_byte_order.sv ----
// Byte assembly of a fetched word according to byte order and aperture
`timescale 1ns/1ps
module bwlo_byte_order (
  // Raw word, byte at lowest address in bits 7:0
  input wire logic [31:0] raw_word,
  // Controls
  input wire logic little_endian,
  input wire logic is_mmio,
  // Result
  output logic [31:0] word
);

  logic [1:0] swap;

  assign swap = little_endian ? bwlo_pkg::BYTE_SWAP_LITTLE : bwlo_pkg::BYTE_SWAP_BIG;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      logic [1:0] idx;
      // Result bits of lane 3-g come from byte (g xor swap)
      assign idx = 2'(g) ^ swap;
      assign word[31 - 8*g -: 8] = is_mmio ? raw_word[31 - 8*g -: 8] : raw_word[8*idx +: 8];
    end
  endgenerate

endmodule // bwlo_byte_order

// ---- hdl/bwlo_pkg.sv ----
// Package of constants and carrier types for the branch and word load unit
package bwlo_pkg;

  // ----------------------------------------
  // Operation codes
  // ----------------------------------------
  localparam logic [7:0] OPC_JUMP_TRUE = 8'hb0;
  localparam logic [7:0] OPC_JUMP_IMM = 8'hb2;
  localparam logic [7:0] OPC_JUMP_FALSE = 8'hb4;
  localparam logic [7:0] OPC_WORD_LOAD = 8'h07;

  // ----------------------------------------
  // Timing and field constants
  // ----------------------------------------
  localparam int BRANCH_DELAY = 3;
  localparam int LOAD_LATENCY = 3;
  localparam logic [1:0] BYTE_SWAP_LITTLE = 2'h3;
  localparam logic [1:0] BYTE_SWAP_BIG = 2'h0;
  localparam int DISP_BITS = 7;
  localparam logic [31:0] MMIO_BASE_RESET = 32'hefe0_0000;
  localparam logic [31:0] MMIO_SIZE = 32'h0020_0000;
  localparam logic [2:0] SLOT_BR_LO = 3'h2;
  localparam logic [2:0] SLOT_BR_HI = 3'h4;
  localparam logic [2:0] SLOT_LD_LO = 3'h4;
  localparam logic [2:0] SLOT_LD_HI = 3'h5;

  // ----------------------------------------
  // Carrier types
  // ----------------------------------------
  typedef struct packed {
    logic valid;
    logic [7:0] opcode;
    logic [2:0] slot;
    logic has_guard;
    logic [31:0] guard;
    logic [31:0] first_source_register;
    logic [31:0] second_source_register;
    logic [31:0] modifier;
    logic [6:0] dest;
  } bwlo_issue_t;

  typedef struct packed {
    logic valid;
    logic [31:0] addr;
    logic cacheable;
  } bwlo_mem_req_t;

  typedef struct packed {
    logic valid;
    logic [6:0] dest;
    logic [31:0] data;
  } bwlo_wb_t;

endpackage

// ---- hdl/bwlo_unit.sv ----
// Branch unit for indirect and immediate jumps plus word load datapath
`timescale 1ns/1ps
module bwlo_unit (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Issue and status
  input wire bwlo_pkg::bwlo_issue_t issue,
  input wire logic [31:0] program_status_word,
  input wire logic byte_order_bit,
  input wire logic [31:0] mmio_base,
  // Data cache side
  output bwlo_pkg::bwlo_mem_req_t mem_req,
  output logic cache_status_update,
  input wire logic [31:0] mem_rdata,
  // Program counter redirect
  output logic pc_load,
  output logic [31:0] pc_target,
  // Register write back
  output bwlo_pkg::bwlo_wb_t wb,
  // Illegal slot indication
  output logic slot_error
);

  // ----------------------------------------
  // Decode
  // ----------------------------------------
  logic guard_ok;
  logic is_jf;
  logic is_jt;
  logic is_ji;
  logic is_ld;
  logic br_slot_ok;
  logic ld_slot_ok;
  logic take;
  logic [31:0] disp;
  logic [31:0] ea;
  logic ea_mmio;

  assign guard_ok = !issue.has_guard || issue.guard[0];
  assign is_jf = issue.valid && issue.opcode == bwlo_pkg::OPC_JUMP_FALSE;
  assign is_jt = issue.valid && issue.opcode == bwlo_pkg::OPC_JUMP_TRUE;
  assign is_ji = issue.valid && issue.opcode == bwlo_pkg::OPC_JUMP_IMM;
  assign is_ld = issue.valid && issue.opcode == bwlo_pkg::OPC_WORD_LOAD;
  assign br_slot_ok = issue.slot >= bwlo_pkg::SLOT_BR_LO && issue.slot <= bwlo_pkg::SLOT_BR_HI;
  assign ld_slot_ok = issue.slot >= bwlo_pkg::SLOT_LD_LO && issue.slot <= bwlo_pkg::SLOT_LD_HI;

  always_comb begin
    take = 1'b0;
    if (guard_ok && br_slot_ok) begin
      if (is_jf) begin
        take = !issue.first_source_register[0];
      end else if (is_jt) begin
        take = issue.first_source_register[0];
      end else if (is_ji) begin
        take = 1'b1;
      end
    end
  end

  // Plain load arrives with a zero modifier, so both forms share this path
  assign disp = {{(32 - bwlo_pkg::DISP_BITS - 2){issue.modifier[bwlo_pkg::DISP_BITS - 1]}},
                 issue.modifier[bwlo_pkg::DISP_BITS - 1:0], 2'b00};
  assign ea = issue.first_source_register + disp;
  // Low address bits are dropped: a misaligned load returns the aligned word, no trap
  assign ea_mmio = (ea - mmio_base) < bwlo_pkg::MMIO_SIZE;

  // ----------------------------------------
  // Branch delay pipeline
  // ----------------------------------------
  logic [bwlo_pkg::BRANCH_DELAY-1:0] br_v_q;
  logic [31:0] br_tgt_q [bwlo_pkg::BRANCH_DELAY];
  logic [31:0] br_tgt_d;

  // Target is picked at issue so the later stages need not know the jump kind
  assign br_tgt_d = is_ji ? issue.modifier : issue.second_source_register;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      br_v_q <= '0;
    end else begin
      br_v_q <= {br_v_q[bwlo_pkg::BRANCH_DELAY-2:0], take};
    end
  end

  genvar gb;
  generate
    for (gb = 0; gb < bwlo_pkg::BRANCH_DELAY; gb++) begin : g_br_stage
      if (gb == 0) begin : g_first
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            br_tgt_q[gb] <= '0;
          end else begin
            br_tgt_q[gb] <= br_tgt_d;
          end
        end
      end else begin : g_next
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            br_tgt_q[gb] <= '0;
          end else begin
            br_tgt_q[gb] <= br_tgt_q[gb-1];
          end
        end
      end
    end
  endgenerate

  assign pc_load = br_v_q[bwlo_pkg::BRANCH_DELAY-1];
  assign pc_target = br_tgt_q[bwlo_pkg::BRANCH_DELAY-1];

  // ----------------------------------------
  // Load request, registered and presented in cycle 1
  // ----------------------------------------
  logic ld_go;

  assign ld_go = is_ld && ld_slot_ok && guard_ok;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= '0;
    end else begin
      mem_req.valid <= ld_go;
      mem_req.addr <= {ea[31:2], 2'b00};
      mem_req.cacheable <= !ea_mmio;
    end
  end

  // Aperture words never touch the cache status bits
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cache_status_update <= 1'b0;
    end else begin
      cache_status_update <= ld_go && !ea_mmio;
    end
  end

  // ----------------------------------------
  // Load return pipeline
  // ----------------------------------------
  // Stages up to the memory answer; the write back register is the last stage
  logic [bwlo_pkg::LOAD_LATENCY-2:0] ld_v_q;
  logic [6:0] ld_dst_q [bwlo_pkg::LOAD_LATENCY-1];
  logic [bwlo_pkg::LOAD_LATENCY-2:0] ld_mmio_q;
  logic [bwlo_pkg::LOAD_LATENCY-2:0] ld_le_q;
  logic [31:0] word;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_v_q <= '0;
    end else begin
      ld_v_q <= {ld_v_q[bwlo_pkg::LOAD_LATENCY-3:0], ld_go};
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_mmio_q <= '0;
    end else begin
      ld_mmio_q <= {ld_mmio_q[bwlo_pkg::LOAD_LATENCY-3:0], ea_mmio};
    end
  end

  // Byte order is frozen at issue, so a later flag change cannot hit a load in flight
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ld_le_q <= '0;
    end else begin
      ld_le_q <= {ld_le_q[bwlo_pkg::LOAD_LATENCY-3:0], byte_order_bit};
    end
  end

  genvar gl;
  generate
    for (gl = 0; gl < bwlo_pkg::LOAD_LATENCY - 1; gl++) begin : g_ld_stage
      if (gl == 0) begin : g_first
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            ld_dst_q[gl] <= '0;
          end else begin
            ld_dst_q[gl] <= issue.dest;
          end
        end
      end else begin : g_next
        always_ff @(posedge clk or negedge rst_n) begin
          if (!rst_n) begin
            ld_dst_q[gl] <= '0;
          end else begin
            ld_dst_q[gl] <= ld_dst_q[gl-1];
          end
        end
      end
    end
  endgenerate

  bwlo_byte_order u_order (
    .raw_word(mem_rdata),
    .little_endian(ld_le_q[bwlo_pkg::LOAD_LATENCY-2]),
    .is_mmio(ld_mmio_q[bwlo_pkg::LOAD_LATENCY-2]),
    .word(word)
  );

  // Data is captured the cycle after the cache answers, latency counted from issue
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wb <= '0;
    end else begin
      wb.valid <= ld_v_q[bwlo_pkg::LOAD_LATENCY-2];
      wb.dest <= ld_dst_q[bwlo_pkg::LOAD_LATENCY-2];
      wb.data <= word;
    end
  end

  // ----------------------------------------
  // Slot check
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      slot_error <= 1'b0;
    end else begin
      slot_error <= ((is_jf || is_jt || is_ji) && !br_slot_ok) || (is_ld && !ld_slot_ok);
    end
  end

endmodule // bwlo_unit

// ---- testbench/bwlo_mem_model.sv ----
// Data memory model that answers word requests one cycle later
`timescale 1ns/1ps
module bwlo_mem_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // Request and answer
  input wire bwlo_pkg::bwlo_mem_req_t mem_req,
  output logic [31:0] mem_rdata
);
  // Word is its scrambled address; between answers the bus toggles
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) mem_rdata <= 32'h0;
    else if (mem_req.valid) mem_rdata <= mem_req.addr ^ 32'h8433_2211;
    else mem_rdata <= ~mem_rdata;
  end
endmodule // bwlo_mem_model

// ---- testbench/bwlo_unit_properties.sv ----
// Port checker for jump and word load timing
`timescale 1ns/1ps
module bwlo_unit_properties (
  // Clock, reset and issue
  input wire logic clk,
  input wire logic rst_n,
  input wire bwlo_pkg::bwlo_issue_t issue,
  // Results
  input wire bwlo_pkg::bwlo_mem_req_t mem_req,
  input wire logic cache_status_update,
  input wire logic [31:0] mem_rdata,
  input wire logic pc_load,
  input wire logic [31:0] pc_target,
  input wire bwlo_pkg::bwlo_wb_t wb
);
  wire g = !issue.has_guard || issue.guard[0];
  wire br = issue.valid && g && issue.slot inside {[3'h2:3'h4]};
  wire ld = issue.valid && issue.slot inside {[3'h4:3'h5]} && issue.opcode == 8'h07;
  wire s1 = issue.first_source_register[0];
  wire [31:0] s2 = issue.second_source_register;
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_jump_false_go: assert property (br && issue.opcode == 8'hb4 && !s1 |-> ##3 pc_load
    && pc_target == $past(s2, 3)) else $error("false jump not taken");
  a_jump_true_go: assert property (br && issue.opcode == 8'hb0 && s1 |-> ##3 pc_load
    && pc_target == $past(s2, 3)) else $error("true jump not taken");
  a_jump_imm_go: assert property (br && issue.opcode == 8'hb2 |-> ##3 pc_load
    && pc_target == $past(issue.modifier, 3)) else $error("immediate jump wrong");
  a_jump_held_off: assert property (issue.valid && !g && issue.opcode[7] |-> ##3 !pc_load)
    else $error("guarded jump taken");
  a_load_wb_lat: assert property (ld && g |-> ##1 mem_req.valid ##2 wb.valid
    && wb.dest == $past(issue.dest, 3)) else $error("load write back late");
  a_load_quiet: assert property (ld && !g |-> ##1 !mem_req.valid && !cache_status_update ##2 !wb.valid)
    else $error("guarded load had effect");
  a_mmio_raw_word: assert property (mem_req.valid && !mem_req.cacheable |-> ##2 wb.data == $past(mem_rdata))
    else $error("aperture word altered");
  a_cache_pair: assert property (mem_req.valid |-> cache_status_update == mem_req.cacheable)
    else $error("cache update mismatch");
endmodule // bwlo_unit_properties
bind bwlo_unit bwlo_unit_properties i_bwlo_unit_properties (.clk, .rst_n, .issue, .mem_req,
  .cache_status_update, .mem_rdata, .pc_load, .pc_target, .wb);

// ---- testbench/tb.sv ----
// Random bench comparing the unit with a model of expected values keyed by cycle
`timescale 1ns/1ps
module tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic bo = 1'b0;
  logic pcl, csu, serr;
  logic [31:0] pct, rd;
  logic [31:0] x = 32'h2a3c;
  bwlo_pkg::bwlo_issue_t issue = '0;
  bwlo_pkg::bwlo_mem_req_t mreq;
  bwlo_pkg::bwlo_wb_t wb;
  logic [63:0] epc[int], ewb[int], emr[int], eer[int];
  logic [7:0] opt[4] = '{8'hb4, 8'hb0, 8'hb2, 8'h07};
  int errors = 0;
  int total_checks = 0;
  int cyc = 0;
  always #12.5 clk = ~clk;
  bwlo_unit i_bwlo_unit (.clk, .rst_n, .issue, .program_status_word(32'h0), .byte_order_bit(bo),
    .mmio_base(bwlo_pkg::MMIO_BASE_RESET), .mem_req(mreq), .cache_status_update(csu), .mem_rdata(rd),
    .pc_load(pcl), .pc_target(pct), .wb, .slot_error(serr));
  bwlo_mem_model i_bwlo_mem_model (.clk, .rst_n, .mem_req(mreq), .mem_rdata(rd));
  function automatic logic [31:0] rnd();
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    x = x ^ (x << 5);
    return x;
  endfunction
  function automatic logic [63:0] at(ref logic [63:0] q[int]);
    return q.exists(cyc) ? q[cyc] : 64'h0;
  endfunction
  task automatic chk(input logic [63:0] seen, input logic [63:0] exp, input string nm);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("[ERR] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic op(input logic [7:0] opc);
    bwlo_pkg::bwlo_issue_t i;
    logic [31:0] ea, w;
    logic ld, ok, m;
    int d;
    @(posedge clk);
    ld = opc == 8'h07;
    i = '{1'b1, opc, 3'h0, x[3], rnd(), rnd(), rnd(), rnd(), x[10:4]};
    i.slot = x[13:11] == 0 ? x[16:14] : ld ? {2'h2, x[14]} : 3'h2 + 3'(x[15:14] % 2'h3);
    if (ld && x[17]) i.first_source_register = bwlo_pkg::MMIO_BASE_RESET + (x & 32'hf_fff0);
    if (ld) i.modifier = x[18] ? x & 32'h7f : 32'h0;
    ok = !i.has_guard || i.guard[0];
    issue <= i;
    if (ld ? i.slot < 4 || i.slot > 5 : i.slot < 2 || i.slot > 4) eer[cyc + 2] = 64'h1;
    else if (ld && ok) begin
      d = 4 * $signed(i.modifier[6:0]);
      ea = i.first_source_register + d;
      ea[1:0] = 2'h0;
      m = ea >= bwlo_pkg::MMIO_BASE_RESET && ea - bwlo_pkg::MMIO_BASE_RESET < bwlo_pkg::MMIO_SIZE;
      w = ea ^ 32'h8433_2211;
      emr[cyc + 2] = {1'b1, !m, !m, ea};
      ewb[cyc + 4] = {1'b1, i.dest, m || bo ? w : {w[7:0], w[15:8], w[23:16], w[31:24]}};
    end else if (ok && (opc == 8'hb2 || i.first_source_register[0] == (opc == 8'hb0)))
      epc[cyc + 4] = {1'b1, opc == 8'hb2 ? i.modifier : i.second_source_register};
  endtask
  always @(negedge clk) begin
    cyc++;
    chk({pcl, pcl ? pct : 32'h0}, at(epc), "pc");
    chk({wb.valid, wb.valid ? {wb.dest, wb.data} : 39'h0}, at(ewb), "wb");
    chk({mreq.valid, csu, mreq.valid ? {mreq.cacheable, mreq.addr} : 33'h0}, at(emr), "mem_req");
    chk(serr, at(eer), "slot_error");
    if (cyc == 3000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    for (int n = 0; n < 400; n++) begin
      if (n % 100 == 0) begin
        @(posedge clk);
        issue.valid <= 1'b0;
        repeat (6) @(posedge clk);
        bo <= ~bo;
      end
      op(opt[rnd() % 4]);
    end
    @(posedge clk);
    issue.valid <= 1'b0;
    repeat (8) @(posedge clk);
    wrap_up();
  end
endmodule // tb
